// [src/spi_transaction_log_builder.v]
// Serial slave that builds and returns the 24-bit transaction log word.
// How it works
// - Read after a read returns error, compact status, data, checksum.
// - Status and checksum sampled at next frame.
// - Compact bits 1-4 OR three switches each.
// - Bit0 pump, bit5 thermal, bit6 zero.
// - Checksum over bits 23:3, x^3+x+1, zero start.
// - First frame: error zero, revision plus pattern.
// - Rejected frame: error one, diagnostics bits 11:8.
// - Qualified write echoes address and payload.
// - Echo is payload, not register contents.
// - General and cluster calls count as writes.
// - After read, write-mode frame returns per-switch status.
// - Per-switch bit n ORs switch n flags.
// - Per-switch bit 12 ORs thermal and pump.
// - First-frame payload: revision, grade, 10001 pattern.
`include "txlog_defines.vh"

module spi_transaction_log_builder #(
  parameter [4:0] REVISION = 5'h01, // Arbitrary revision value.
  parameter [2:0] GRADE = 3'h0 // Arbitrary grade value.
) (
  // Clock and reset.
  input wire clk_sys_in,
  input wire nrst_in,
  // Serial pins from the master.
  input wire sclk_in,
  input wire cs_n_in,
  input wire sdi_in,
  // Serial data pin back to the master.
  output reg sdo_out,
  output reg sdo_oe_out,
  // Fault flags from the detection logic, same clock.
  input wire [11:0] open_led_flags_in,
  input wire [11:0] open_trace_flags_in,
  input wire [11:0] short_led_flags_in,
  input wire pump_not_ready_in,
  input wire thermal_shutdown_in,
  input wire thermal_warning_in,
  input wire config_not_done_in,
  input wire grade_not_ready_in,
  // Configuration held in the register map.
  output reg update_go_enable_out,
  output reg [4:0] chip_slot_id_out,
  output reg [8:0] general_config_out,
  output reg [6:0] fault_mask_out
);

  // --------------------------------------------------------------------
  // Status summaries
  // --------------------------------------------------------------------

  // Compact seven-bit status word.
  function [6:0] compact_status;
    input [11:0] ol, ot, sl;
    input pump, shdn, warn;
    reg [11:0] any;
    begin
      any = ol | ot | sl;
      compact_status[0] = pump;
      compact_status[1] = |any[2:0];
      compact_status[2] = |any[5:3];
      compact_status[3] = |any[8:6];
      compact_status[4] = |any[11:9];
      compact_status[5] = shdn | warn;
      compact_status[6] = 1'b0;
    end
  endfunction

  // Per-switch thirteen-bit status word.
  function [12:0] per_switch_status;
    input [11:0] ol, ot, sl;
    input pump, shdn, warn;
    begin
      per_switch_status[11:0] = ol | ot | sl;
      per_switch_status[12] = shdn | warn | pump;
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------

  // Synchronised pins: {sclk, select active, sdi}.
  // Select travels inverted so the synchroniser's all-zero reset reads as idle.
  // Otherwise a false frame would start and end just after reset.
  wire [2:0] pins_s;
  // Synchronised active-low select, high while idle.
  wire cs_n_s;
  // Previous synchronised clock and select, for edges.
  reg sclk_d1_q;
  reg cs_n_d1_q;

  txlog_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({sclk_in, ~cs_n_in, sdi_in}),
    .sync_out(pins_s)
  );

  // Back to the pin's polarity for the edge logic.
  assign cs_n_s = ~pins_s[1];

  // Edge events in the system domain.
  wire sclk_rise = pins_s[2] & ~sclk_d1_q;
  wire sclk_fall = ~pins_s[2] & sclk_d1_q;
  wire frame_start = ~cs_n_s & cs_n_d1_q;
  wire frame_end = cs_n_s & ~cs_n_d1_q;
  wire in_frame = ~cs_n_s;

  // Delay stage for edge detection.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sclk_d1_q <= 1'b0;
      cs_n_d1_q <= 1'b1;
    end else begin
      sclk_d1_q <= pins_s[2];
      cs_n_d1_q <= cs_n_s;
    end
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------

  reg [1:0] class_q; // Class of the previous transaction.
  reg [6:0] last_addr_q; // Address of the last qualified frame.
  reg [12:0] last_data_q; // Payload or read data of the last qualified frame.
  reg [3:0] diag_q; // Sticky {clock, checksum, write, read} errors.
  reg [2:0] sft_q; // Serial test bits of the port config.
  reg [23:0] rx_q; // Incoming command shift register.
  reg [4:0] count_q; // Rising edges seen in this frame, saturating.
  reg [23:0] tx_q; // Outgoing response shift register.
  reg [22:0] alt_q; // Read-mode response tail, swapped in on demand.

  // Live summaries; used at frame start so they are fresh.
  wire [6:0] cstat = compact_status(open_led_flags_in, open_trace_flags_in,
    short_led_flags_in, pump_not_ready_in, thermal_shutdown_in, thermal_warning_in);
  wire [12:0] pstat = per_switch_status(open_led_flags_in, open_trace_flags_in,
    short_led_flags_in, pump_not_ready_in, thermal_shutdown_in, thermal_warning_in);
  wire spi_err = |diag_q;

  // --------------------------------------------------------------------
  // Response words
  // --------------------------------------------------------------------

  // Body of the write-mode response, bits 23:3.
  reg [20:0] wr_body;

  // content chosen by the previous class.
  always @* begin
    case (class_q)
      `CLASS_INITIAL: wr_body = {1'b0, 7'h00, REVISION, GRADE, `POWER_UP_PATTERN};
      `CLASS_REJECTED: wr_body = {1'b1, 7'h00, 4'h0, diag_q, 5'h00};
      `CLASS_QWRITE: wr_body = {spi_err, last_addr_q, last_data_q};
      `CLASS_QREAD: wr_body = {spi_err, last_addr_q, pstat};
      default: wr_body = 21'h000000;
    endcase
  end

  wire [20:0] rd_body = {spi_err, cstat, last_data_q};
  wire [2:0] wr_crc;
  wire [2:0] rd_crc;
  wire [2:0] rx_crc;

  txlog_crc3 u_crc_wr (
    .msg_in(wr_body),
    .crc_out(wr_crc)
  );

  txlog_crc3 u_crc_rd (
    .msg_in(rd_body),
    .crc_out(rd_crc)
  );

  // The command is checked with the same polynomial.
  txlog_crc3 u_crc_rx (
    .msg_in(rx_q[23:3]),
    .crc_out(rx_crc)
  );

  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------

  wire rx_read = rx_q[`FRAME_MODE_BIT];
  wire [6:0] rx_addr = rx_q[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
  wire [12:0] rx_data = rx_q[`FRAME_DATA_HI:`FRAME_DATA_LO];
  wire len_ok = (count_q == 5'h18);
  wire crc_ok = (rx_crc == rx_q[2:0]);
  wire is_call = (rx_addr == `ADDR_CLUSTER_CALL) || (rx_addr == `ADDR_GENERAL_CALL);
  wire rd_ok = (rx_addr <= `ADDR_GENERAL_STATUS);
  wire wr_ok = ((rx_addr >= `ADDR_GLOBAL_UPDATE_ENABLE) &&
    (rx_addr <= `ADDR_FAULT_MASK_CONFIG)) || is_call;
  wire qualified = len_ok && crc_ok && (rx_read ? rd_ok : wr_ok);

  // Register read mux; data word is the low 13 bits.
  reg [15:0] rd_word;

  always @* begin
    case (rx_addr)
      `ADDR_IDENTITY_AND_TEST: rd_word = {3'h0, REVISION, GRADE, `POWER_UP_PATTERN};
      `ADDR_GLOBAL_UPDATE_ENABLE: rd_word = {15'h0000, update_go_enable_out};
      `ADDR_SERIAL_PORT_CONFIG: rd_word = {3'h0, chip_slot_id_out, diag_q, 1'b0, sft_q};
      `ADDR_GENERAL_CONFIG: rd_word = {7'h00, general_config_out};
      `ADDR_FAULT_MASK_CONFIG: rd_word = {9'h000, fault_mask_out};
      `ADDR_GENERAL_STATUS: rd_word = {6'h00, config_not_done_in, grade_not_ready_in,
        1'b0, spi_err, |open_trace_flags_in, |open_led_flags_in,
        |short_led_flags_in, pump_not_ready_in, thermal_shutdown_in,
        thermal_warning_in};
      default: rd_word = 16'h0000;
    endcase
  end

  // Errors raised by a failing frame; set and clear never fall in the same frame.
  wire [3:0] diag_set = {~len_ok, len_ok & ~crc_ok,
    len_ok & crc_ok & ~rx_read & ~wr_ok, len_ok & crc_ok & rx_read & ~rd_ok};
  wire diag_clr_wr = frame_end && qualified && !rx_read &&
    (rx_addr == `ADDR_SERIAL_PORT_CONFIG);

  // --------------------------------------------------------------------
  // Serial shifting
  // --------------------------------------------------------------------

  // Receive on rising clock, transmit on falling clock.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_q <= 24'h000000;
      count_q <= 5'h00;
      tx_q <= 24'h000000;
      alt_q <= 23'h000000;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (frame_start) begin
      tx_q <= {wr_body, wr_crc};
      alt_q <= {rd_body[19:0], rd_crc};
      count_q <= 5'h00;
      sdo_out <= wr_body[20];
      sdo_oe_out <= 1'b1;
    end else if (in_frame) begin
      if (sclk_rise) begin
        rx_q <= {rx_q[22:0], pins_s[0]};
        if (count_q != 5'h1f) begin
          count_q <= count_q + 5'h01;
        end
        if (count_q == 5'h00 && pins_s[0] && class_q == `CLASS_QREAD) begin
          tx_q[22:0] <= alt_q;
        end
      end else if (sclk_fall) begin
        tx_q <= {tx_q[22:0], 1'b0};
        sdo_out <= tx_q[22];
      end
    end else begin
      // Release the pin between frames.
      sdo_oe_out <= 1'b0;
      sdo_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Execution and register map
  // --------------------------------------------------------------------

  // Commands take effect when select rises.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      class_q <= `CLASS_INITIAL;
      last_addr_q <= 7'h00;
      last_data_q <= 13'h0000;
      diag_q <= 4'h0;
      sft_q <= 3'h0;
      update_go_enable_out <= `RST_UPDATE_GO;
      chip_slot_id_out <= 5'h00;
      general_config_out <= `RST_GENERAL_CONFIG;
      fault_mask_out <= `RST_FAULT_MASK;
    end else if (frame_end) begin
      if (!qualified) begin
        class_q <= `CLASS_REJECTED;
        diag_q <= diag_q | diag_set;
      end else if (rx_read) begin
        class_q <= `CLASS_QREAD;
        last_addr_q <= rx_addr;
        last_data_q <= rd_word[12:0];
      end else begin
        class_q <= `CLASS_QWRITE;
        last_addr_q <= rx_addr;
        last_data_q <= rx_data;
        case (rx_addr)
          `ADDR_GLOBAL_UPDATE_ENABLE: update_go_enable_out <= rx_data[0];
          `ADDR_SERIAL_PORT_CONFIG: begin
            chip_slot_id_out <= rx_data[12:8];
            sft_q <= rx_data[2:0];
          end
          `ADDR_GENERAL_CONFIG: general_config_out <= rx_data[8:0];
          `ADDR_FAULT_MASK_CONFIG: fault_mask_out <= rx_data[6:0];
          // Broadcasts only trigger the global update.
          default: update_go_enable_out <= rx_data[0];
        endcase
        // Writing ones to the error bits clears them.
        if (diag_clr_wr) begin
          diag_q <= diag_q & ~rx_data[7:4];
        end
      end
    end
  end

endmodule // spi_transaction_log_builder

// [src/txlog_crc3.v]
// Three-bit checksum over a message, most significant bit first.
`include "txlog_defines.vh"

module txlog_crc3 #(
  parameter MSG_BITS = `CRC_MSG_BITS
) (
  // Message in, checksum out.
  input wire [MSG_BITS-1:0] msg_in,
  output reg [2:0] crc_out
);

  // Loop index.
  integer i;
  // Feedback bit of the current step.
  reg fb;

  // Shift each message bit into the register; poly x^3+x+1.
  always @* begin
    crc_out = `CRC_INIT;
    fb = 1'b0;
    for (i = MSG_BITS - 1; i >= 0; i = i - 1) begin
      fb = msg_in[i] ^ crc_out[2];
      crc_out = {crc_out[1:0], 1'b0} ^ ({3{fb}} & `CRC_POLY);
    end
  end

endmodule // txlog_crc3

// [src/txlog_defines.vh]
// Constants for the serial transaction log builder and its register map.
`ifndef TXLOG_DEFINES_VH
`define TXLOG_DEFINES_VH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_MODE_BIT 23
`define FRAME_ADDR_HI 22
`define FRAME_ADDR_LO 16
`define FRAME_DATA_HI 15
`define FRAME_DATA_LO 3
`define CRC_BITS 3
`define CRC_MSG_BITS 21
`define CRC_POLY 3'h3
`define CRC_INIT 3'h0

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_IDENTITY_AND_TEST 7'h00
`define ADDR_GLOBAL_UPDATE_ENABLE 7'h01
`define ADDR_SERIAL_PORT_CONFIG 7'h02
`define ADDR_GENERAL_CONFIG 7'h03
`define ADDR_FAULT_MASK_CONFIG 7'h04
`define ADDR_GENERAL_STATUS 7'h05
`define ADDR_CLUSTER_CALL 7'h7e
`define ADDR_GENERAL_CALL 7'h7f

// ----------------------------------------------------------------------
// Reset values and fixed patterns
// ----------------------------------------------------------------------
`define RST_UPDATE_GO 1'h0
`define RST_GENERAL_CONFIG 9'h000
`define RST_FAULT_MASK 7'h00
`define RST_SPI_CONFIG 8'h00
`define POWER_UP_PATTERN 5'h11

// ----------------------------------------------------------------------
// Previous transaction classes
// ----------------------------------------------------------------------
`define CLASS_INITIAL 2'h0
`define CLASS_REJECTED 2'h1
`define CLASS_QWRITE 2'h2
`define CLASS_QREAD 2'h3

`endif

// [src/txlog_sync.v]
// Two-flop synchroniser for the serial pins.
module txlog_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset.
  input wire clk_sys_in,
  input wire nrst_in,
  // Asynchronous levels in, synchronised levels out.
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // First stage; read only by the second stage.
  reg [WIDTH-1:0] meta_q;

  // Two stages give the first flop a full cycle to settle.
  always @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // txlog_sync

// [verif/spi_master_model.sv]
// Serial master model: mode 0 frames, MSB first, sampling on the rise.
module spi_master_model (
  // Pins toward the device.
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands low and select high outside frames.
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // A count other than 24 makes a deliberately broken frame.
  // MSB first shift
  task automatic frame(input logic [23:0] cmd, input int nrise, output logic [23:0] resp);
    #1.3;
    cs_n_out = 1'b0;
    #24;
    for (int i = 0; i < nrise; i++) begin
      sdi_out = (i < 24) ? cmd[23-i] : 1'b0;
      #24;
      resp = {resp[22:0], sdo_in};
      sclk_out = 1'b1;
      #24;
      sclk_out = 1'b0;
    end
    #24;
    cs_n_out = 1'b1;
    // Released line shows the inverse so a stale value is never trusted.
    sdi_out = ~sdi_out;
    #40;
  endtask
endmodule // spi_master_model

// [verif/spi_transaction_log_builder_checker.sv]
// Pin-level concurrent checks for the transaction log builder.
module spi_transaction_log_builder_checker (
  // Clock and reset.
  input wire clk_sys_in,
  input wire nrst_in,
  // Serial pins.
  input wire sclk_in,
  input wire cs_n_in,
  input wire sdo_out,
  input wire sdo_oe_out,
  // Register map outputs.
  input wire update_go_enable_out,
  input wire [4:0] chip_slot_id_out,
  input wire [8:0] general_config_out,
  input wire [6:0] fault_mask_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // All writable output registers in one vector.
  wire [21:0] cfg_w = {update_go_enable_out, chip_slot_id_out, general_config_out, fault_mask_out};
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_idle; cs_n_in [*6]; endsequence
  sequence s_sel; !cs_n_in [*8]; endsequence
  sequence s_hi; sclk_in [*5]; endsequence
  property p_idle_oe; @(posedge clk_sys_in) disable iff (!nrst_in) s_idle |-> !sdo_oe_out;
  endproperty
  a_idle_oe: assert property (p_idle_oe) else $error("enable high between frames");
  property p_sel_oe; @(posedge clk_sys_in) disable iff (!nrst_in) s_sel |-> sdo_oe_out;
  endproperty
  a_sel_oe: assert property (p_sel_oe) else $error("enable low inside frame");
  property p_quiet; @(posedge clk_sys_in) disable iff (!nrst_in) !sdo_oe_out |-> !sdo_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data driven while disabled");
  property p_hold; @(posedge clk_sys_in) disable iff (!nrst_in) s_hi |-> $stable(sdo_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved while clock high");
  property p_cfg_frame; @(posedge clk_sys_in) disable iff (!nrst_in) s_sel |-> $stable(cfg_w);
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("register moved mid frame");
  property p_cfg_exec; @(posedge clk_sys_in) disable iff (!nrst_in)
    $changed(cfg_w) |-> cs_n_in && $past(cs_n_in, 2);
  endproperty
  a_cfg_exec: assert property (p_cfg_exec) else $error("register moved outside execute");
  // Reset clears registers and the pin driver on the next edge.
  property p_rst; @(posedge clk_sys_in) !nrst_in |=> cfg_w == 22'h0 && !sdo_oe_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_oe_rise; @(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(sdo_oe_out) |-> $past(cs_n_in, 2) == 1'b0;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("enable rose without select");
  property p_oe_fall; @(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(sdo_oe_out) |-> $past(cs_n_in, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("enable fell while selected");
endmodule // spi_transaction_log_builder_checker

bind spi_transaction_log_builder spi_transaction_log_builder_checker i_chk (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .update_go_enable_out(update_go_enable_out),
  .chip_slot_id_out(chip_slot_id_out), .general_config_out(general_config_out),
  .fault_mask_out(fault_mask_out));

// [verif/tb_spi_transaction_log_builder.sv]
// Self-checking bench for the transaction log builder.
`include "txlog_defines.vh"
module tb_spi_transaction_log_builder;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] REV = 5'h16; // Arbitrary revision for the run.
  localparam logic [2:0] GRD = 3'h5; // Arbitrary grade for the run.
  logic clk_sys_in, nrst_in, sclk, cs_n, sdi, sdo, sdo_oe, go, pump, shdn, warn, cnd, gnr;
  logic [11:0] ol, ot, sl;
  logic [4:0] chip_slot_id;
  logic [8:0] cfg;
  logic [6:0] msk;
  // Reference state of the device.
  logic go_exp;
  logic [4:0] cid_exp;
  logic [8:0] cfg_exp;
  logic [6:0] msk_exp;
  logic [3:0] errs;
  logic [1:0] cls;
  logic [6:0] paddr;
  logic [12:0] pdata;
  int error_cnt, comparisons;
  logic [6:0] rd_tbl [4] = '{7'h00, 7'h01, 7'h03, 7'h04};
  logic [6:0] wr_tbl [6] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h7e, 7'h7f};
  spi_transaction_log_builder #(.REVISION(REV), .GRADE(GRD)) i_spi_transaction_log_builder (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .open_led_flags_in(ol), .open_trace_flags_in(ot),
    .short_led_flags_in(sl), .pump_not_ready_in(pump), .thermal_shutdown_in(shdn),
    .thermal_warning_in(warn), .config_not_done_in(cnd), .grade_not_ready_in(gnr),
    .update_go_enable_out(go), .chip_slot_id_out(chip_slot_id), .general_config_out(cfg),
    .fault_mask_out(msk));
  spi_master_model u_master (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo));
  // ----------------------------------------------------------------
  // Reference functions
  // ----------------------------------------------------------------
  // checksum, zero start
  function automatic logic [2:0] crc3(input logic [20:0] m);
    logic [2:0] c;
    logic fb;
    c = 3'h0;
    for (int i = 20; i >= 0; i--) begin
      fb = m[i] ^ c[2];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction
  function automatic logic [12:0] rdata(input logic [6:0] a);
    case (a)
      7'h00: return {REV, GRD, `POWER_UP_PATTERN};
      7'h01: return {12'h000, go_exp};
      7'h03: return {4'h0, cfg_exp};
      default: return {6'h00, msk_exp};
    endcase
  endfunction
  // Word due in the coming frame; flags are held through the frame.
  function automatic logic [23:0] exp_resp(input logic mode);
    logic [20:0] m;
    logic [11:0] g;
    g = ol | ot | sl;
    case (cls)
      `CLASS_INITIAL: m = {1'b0, 7'h00, REV, GRD, `POWER_UP_PATTERN};
      `CLASS_REJECTED: m = {1'b1, 11'h000, errs, 5'h00};
      `CLASS_QWRITE: m = {|errs, paddr, pdata};
      default: m = mode ? {|errs, 1'b0, shdn | warn, |g[11:9], |g[8:6], |g[5:3], |g[2:0],
        pump, rdata(paddr)} : {|errs, paddr, shdn | warn | pump, g};
    endcase
    return {m, crc3(m)};
  endfunction
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rej(input int b);
    errs[b] = 1'b1;
    cls = `CLASS_REJECTED;
  endtask
  // One frame: fresh flags, exchange, compare, then advance the reference.
  task automatic run(input logic mode, input logic [6:0] a, input logic [12:0] d,
    input int n = 24, input logic bad = 1'b0);
    logic [23:0] cmd, e, got;
    @(negedge clk_sys_in);
    {ol, ot, sl} = {$urandom, $urandom} & {$urandom, $urandom};
    {pump, shdn, warn, cnd, gnr} = $urandom & $urandom;
    e = exp_resp(mode);
    cmd = {mode, a, d, 3'h0};
    cmd[2:0] = crc3(cmd[23:3]) ^ {2'b00, bad};
    u_master.frame(cmd, n, got);
    if (n == 24) chk("response", e, got);
    if (n != 24) rej(3);
    else if (bad) rej(2);
    else if (mode && a > 7'h05) rej(0);
    else if (mode) begin
      cls = `CLASS_QREAD;
      paddr = a;
    end else if (!(a inside {[7'h01:7'h04], 7'h7e, 7'h7f})) rej(1);
    else begin
      cls = `CLASS_QWRITE;
      paddr = a;
      pdata = d;
      case (a)
        7'h02: begin
          cid_exp = d[12:8];
          errs = errs & ~d[7:4];
        end
        7'h03: cfg_exp = d[8:0];
        7'h04: msk_exp = d[6:0];
        default: go_exp = d[0];
      endcase
    end
    chk("config", {go_exp, cid_exp, cfg_exp, msk_exp}, {go, chip_slot_id, cfg, msk});
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    error_cnt++;
    final_report();
  end
  initial begin
    logic m;
    logic [12:0] d;
    int k;
    nrst_in = 1'b0;
    {ol, ot, sl, pump, shdn, warn, cnd, gnr} = '0;
    {go_exp, cid_exp, cfg_exp, msk_exp, errs, paddr, pdata} = '0;
    cls = `CLASS_INITIAL;
    void'($urandom(33588));
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in) nrst_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    // Power-up word, then an echo that differs from the stored bit.
    run(0, 7'h01, 13'h1fff);
    run(0, 7'h03, 13'h0155);
    $display("test power_up done");
    // Reads back to back, then a write after a read.
    run(1, 7'h00, 13'h0);
    run(1, 7'h03, 13'h0);
    run(1, 7'h04, 13'h0);
    run(0, 7'h04, 13'h0055);
    $display("test read_chain done");
    // Every refusal, two clears, and both call commands.
    run(0, 7'h01, 13'h0, 23);
    run(0, 7'h01, 13'h0, 24, 1'b1);
    run(0, 7'h00, 13'h1);
    run(1, 7'h06, 13'h0);
    run(0, 7'h02, 13'h1ff0);
    run(0, 7'h7f, 13'h0001);
    run(0, 7'h7e, 13'h0000, 25);
    run(0, 7'h7e, 13'h0000);
    run(0, 7'h02, 13'h00f0);
    $display("test refusals done");
    // Random traffic with occasional refusals.
    repeat (60) begin
      m = $urandom;
      d = $urandom;
      k = $urandom_range(0, 15);
      if (!m && k > 8) d[3:0] = 4'h0;
      run(m, (k == 0) ? 7'h55 : (m ? rd_tbl[k % 4] : wr_tbl[k % 6]), d, (k == 1) ? 23 : 24,
        k == 2);
    end
    $display("test random done");
    final_report();
  end
endmodule // tb_spi_transaction_log_builder
